// ---- rtl/gptc_pkg.sv ----
// Package: register map, field positions, reset values and timing of the timer/counter block
package gptc_pkg;

   // ************************************************************
   // Register offsets (byte-wide registers)
   // ************************************************************
   localparam logic [3:0] OFF_RUN_MODE = 4'h0;   // Run and timer/counter select, all units
   localparam logic [3:0] OFF_U2_CTRL  = 4'h1;   // Third unit options
   localparam logic [3:0] OFF_CNT_BASE = 4'h2;   // Low byte of unit 0, then high, per unit
   localparam logic [3:0] OFF_RLD_LO   = 4'h8;   // Reload value, low byte
   localparam logic [3:0] OFF_RLD_HI   = 4'h9;   // Reload value, high byte
   localparam logic [3:0] OFF_CAP_LO   = 4'hA;   // Captured count, low byte
   localparam logic [3:0] OFF_CAP_HI   = 4'hB;   // Captured count, high byte
   localparam logic [3:0] OFF_STATUS   = 4'hC;   // Sticky event flags, write one to clear
   localparam logic [3:0] OFF_MASK     = 4'hD;   // Interrupt enables, same layout

   // ************************************************************
   // Field positions
   // ************************************************************
   // Run/mode register: bit 2u runs unit u, bit 2u+1 selects event counting
   localparam int RM_RUN_POS   = 0;
   localparam int RM_MODE_POS  = 1;
   // Third unit control
   localparam int U2_CAP_POS   = 0;   // Capture on trigger fall
   localparam int U2_RLD_POS   = 1;   // Auto-reload operation
   localparam int U2_UPDN_POS  = 2;   // Trigger level picks direction in reload mode
   localparam int U2_TRIG_POS  = 3;   // Trigger fall forces a reload
   localparam int U2_OUT_POS   = 4;   // Timer output toggles on each wrap
   // Status and mask: bits 0..2 unit wraps, bit 3 trigger event
   localparam int ST_TRIG_POS  = 3;
   localparam int ST_W         = 4;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]  RST_CTRL  = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [ST_W-1:0] RST_FLAGS = 4'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 10;   // One machine cycle per clock
   localparam int EDGE_RECOG_CYC = 2;    // Two samples make one edge

endpackage

// ---- rtl/gptc_unit.sv ----
// One 16-bit timer/counter: edge sampling, count, reload and wrap detection
`timescale 1ns/1ns
`default_nettype none

module gptc_unit
   import gptc_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rstn,
   // Operating control
   input  wire logic         run,
   input  wire logic         ext_mode,
   input  wire logic         ext_pin,
   input  wire logic         auto_rld,
   input  wire logic         down,
   input  wire logic [W-1:0] rld_val,
   input  wire logic         force_ld,
   // Software writes
   input  wire logic         wr_lo,
   input  wire logic         wr_hi,
   input  wire logic [7:0]   wr_byte,
   // Count state
   output logic [W-1:0]      count,
   output logic              wrap
);

   // Byte access needs a low and a partial or full high byte
   if (W <= 8 || W > 16) begin : g_bad_width
      $error("gptc_unit: W must be 9..16");
   end

   logic [W-1:0] count_reg;
   logic         samp_reg;
   logic         prev_reg;
   logic         fall;
   logic         tick;
   logic         at_end;
   logic         sw_wr;

   // Pin sampled once per machine cycle, previous sample kept
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         samp_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         samp_reg <= ext_pin;
         prev_reg <= samp_reg;
      end
   end

   // High then low sample is one event
   assign fall   = prev_reg & ~samp_reg;
   assign tick   = run & (ext_mode ? fall : 1'b1);
   assign at_end = down ? (count_reg == rld_val) : (count_reg == {W{1'b1}});
   assign sw_wr  = wr_lo | wr_hi;
   // A software write or a forced load takes the cycle, so no wrap
   assign wrap   = tick & at_end & ~sw_wr & ~force_ld;
   assign count  = count_reg;

   // Count register; software write wins over counting
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= RST_COUNT[W-1:0];
      end else if (sw_wr) begin
         if (wr_lo) begin
            count_reg[7:0] <= wr_byte;
         end
         if (wr_hi) begin
            count_reg[W-1:8] <= wr_byte[W-9:0];
         end
      end else if (force_ld) begin
         count_reg <= rld_val;
      end else if (tick) begin
         if (at_end) begin
            count_reg <= down ? {W{1'b1}} : (auto_rld ? rld_val : '0);
         end else begin
            count_reg <= down ? count_reg - 1'b1 : count_reg + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ---- rtl/gptc_top.sv ----
// Three general purpose 16-bit timer/counters with register port and interrupt
// What this block does
// - Three independent 16-bit units each run as a cycle timer or an event counter.
// - The units can raise periodic interrupt requests toward the processor.
// - In timer operation the count steps by one every machine cycle, up, or down in the third unit's down mode.
// - In counter operation the count steps only on a falling edge of the unit's pin, up, or down in the third unit's down mode.
// - Each pin is sampled once per cycle and high then low marks an event.
// - The new count is visible in the cycle after the edge was detected.
// - Edge recognition takes two machine cycles, limiting the event rate.
// - The third unit can also count 16 bits as a plain timer or counter.
// - The third unit can capture its 16-bit count while counting goes on.
// - The third unit offers 16-bit auto-reload, up or down, and a timer output.
// - A trigger pin starts capture or reload and can select the count direction.
// - The third unit has its own event pin for counter operation.
`timescale 1ns/1ns
`default_nettype none

module gptc_top
   import gptc_pkg::*;
#(
   parameter int CW = 16
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   // Event and trigger pins
   input  wire logic       event_input_zero,
   input  wire logic       event_input_one,
   input  wire logic       event_input_two,
   input  wire logic       capture_reload_trigger,
   // Outputs
   output logic            tmr_out,
   output logic            irq
);

   // ************************************************************
   // Elaboration check
   // ************************************************************
   // Low and high byte registers only cover exactly 16 bits
   if (CW != 16) begin : g_bad_cw
      $error("gptc_top: CW must be 16");
   end

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]      run_mode_reg;
   logic [7:0]      u2_ctrl_reg;
   logic [CW-1:0]   rld_reg;
   logic [CW-1:0]   cap_reg;
   logic [ST_W-1:0] status_reg;
   logic [ST_W-1:0] status_next;
   logic [ST_W-1:0] mask_reg;
   logic [7:0]      rd_data_reg;
   logic [7:0]      rd_mux;
   logic            tmr_out_reg;
   logic            irq_reg;
   logic            trig_samp_reg;
   logic            trig_prev_reg;
   logic            trig_fall;
   logic            cap_mode;
   logic            rld_mode;
   logic            updn_mode;
   logic            trig_evt;
   logic [2:0]      ev_pin;
   logic [2:0]      u_auto;
   logic [2:0]      u_down;
   logic [2:0]      u_fld;
   logic [2:0]      u_wrap;
   logic [CW-1:0]   u_cnt [3];

   // Write hit on one register, used by every write decode
   function automatic logic wr_hit(input logic       we,
                                   input logic [3:0] a,
                                   input logic [3:0] off);
      wr_hit = we && (a == off);
   endfunction

   // ************************************************************
   // Trigger pin and third unit modes
   // ************************************************************
   // Trigger sampled per cycle like the event pins
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         trig_samp_reg <= 1'b1;
         trig_prev_reg <= 1'b1;
      end else begin
         trig_samp_reg <= capture_reload_trigger;
         trig_prev_reg <= trig_samp_reg;
      end
   end

   assign trig_fall = trig_prev_reg & ~trig_samp_reg;
   // Capture takes precedence, so the two modes never mix
   assign cap_mode  = u2_ctrl_reg[U2_CAP_POS];
   assign rld_mode  = u2_ctrl_reg[U2_RLD_POS] & ~cap_mode;
   assign updn_mode = rld_mode & u2_ctrl_reg[U2_UPDN_POS];
   // Direction pin low counts down; trigger reload is off while it steers
   assign u_down    = {updn_mode & ~trig_samp_reg, 2'b00};
   assign u_auto    = {rld_mode, 2'b00};
   assign u_fld     = {rld_mode & ~updn_mode & u2_ctrl_reg[U2_TRIG_POS] & trig_fall, 2'b00};
   assign trig_evt  = trig_fall & (cap_mode | u_fld[2]);
   assign ev_pin    = {event_input_two, event_input_one, event_input_zero};

   // ************************************************************
   // Three counting units
   // ************************************************************
   for (genvar u = 0; u < 3; u++) begin : g_unit
      gptc_unit #(
         .W (CW)
      ) u_unit (
         .mclk     (mclk),
         .rstn     (rstn),
         .run      (run_mode_reg[2*u+RM_RUN_POS]),
         .ext_mode (run_mode_reg[2*u+RM_MODE_POS]),
         .ext_pin  (ev_pin[u]),
         .auto_rld (u_auto[u]),
         .down     (u_down[u]),
         .rld_val  (rld_reg),
         .force_ld (u_fld[u]),
         .wr_lo    (wr_hit(wr_en, addr, OFF_CNT_BASE + 4'(2*u))),
         .wr_hi    (wr_hit(wr_en, addr, OFF_CNT_BASE + 4'(2*u+1))),
         .wr_byte  (wr_data),
         .count    (u_cnt[u]),
         .wrap     (u_wrap[u])
      );
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   // Run/mode and third unit options
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_mode_reg <= RST_CTRL;
         u2_ctrl_reg  <= RST_CTRL;
      end else begin
         if (wr_hit(wr_en, addr, OFF_RUN_MODE)) begin
            run_mode_reg <= wr_data;
         end
         if (wr_hit(wr_en, addr, OFF_U2_CTRL)) begin
            u2_ctrl_reg <= wr_data;
         end
      end
   end

   // Reload value, written a byte at a time
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rld_reg <= RST_COUNT;
      end else begin
         if (wr_hit(wr_en, addr, OFF_RLD_LO)) begin
            rld_reg[7:0] <= wr_data;
         end
         if (wr_hit(wr_en, addr, OFF_RLD_HI)) begin
            rld_reg[15:8] <= wr_data;
         end
      end
   end

   // Capture holds the count seen in the cycle the trigger fall is known
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cap_reg <= RST_COUNT;
      end else if (cap_mode && trig_fall) begin
         cap_reg <= u_cnt[2];
      end
   end

   // ************************************************************
   // Status, mask and interrupt
   // ************************************************************
   // Set wins over a clear written in the same cycle, so no event is lost
   always_comb begin
      status_next = status_reg;
      if (wr_hit(wr_en, addr, OFF_STATUS)) begin
         status_next = status_next & ~wr_data[ST_W-1:0];
      end
      status_next = status_next | {trig_evt, u_wrap};
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status_reg <= RST_FLAGS;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mask_reg <= RST_FLAGS;
      end else if (wr_hit(wr_en, addr, OFF_MASK)) begin
         mask_reg <= wr_data[ST_W-1:0];
      end
   end

   // Level request while any enabled flag stands; one cycle behind the flag
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   // ************************************************************
   // Timer output generator
   // ************************************************************
   // Square wave at half the third unit's wrap rate
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tmr_out_reg <= 1'b0;
      end else if (u2_ctrl_reg[U2_OUT_POS] && u_wrap[2]) begin
         tmr_out_reg <= ~tmr_out_reg;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Unmapped offsets read as zero
   always_comb begin
      case (addr)
         OFF_RUN_MODE: rd_mux = run_mode_reg;
         OFF_U2_CTRL:  rd_mux = u2_ctrl_reg;
         4'h2:         rd_mux = u_cnt[0][7:0];
         4'h3:         rd_mux = u_cnt[0][15:8];
         4'h4:         rd_mux = u_cnt[1][7:0];
         4'h5:         rd_mux = u_cnt[1][15:8];
         4'h6:         rd_mux = u_cnt[2][7:0];
         4'h7:         rd_mux = u_cnt[2][15:8];
         OFF_RLD_LO:   rd_mux = rld_reg[7:0];
         OFF_RLD_HI:   rd_mux = rld_reg[15:8];
         OFF_CAP_LO:   rd_mux = cap_reg[7:0];
         OFF_CAP_HI:   rd_mux = cap_reg[15:8];
         OFF_STATUS:   rd_mux = {4'h0, status_reg};
         OFF_MASK:     rd_mux = {4'h0, mask_reg};
         default:      rd_mux = 8'h00;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_data_reg <= 8'h00;
      end else begin
         rd_data_reg <= rd_en ? rd_mux : 8'h00;
      end
   end

   assign rd_data = rd_data_reg;
   assign tmr_out = tmr_out_reg;
   assign irq     = irq_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_timer_step: assert property (
      (run_mode_reg[0] && !run_mode_reg[1] && !wr_en && u_cnt[0] != 16'hFFFF)
      |=> u_cnt[0] == $past(u_cnt[0]) + 16'h0001)
      else $error("unit 0 timer did not step by one");

   a_unit1_indep: assert property (
      (!run_mode_reg[2] && !wr_en) |=> $stable(u_cnt[1]))
      else $error("stopped unit 1 changed its count");

   a_counter_hold: assert property (
      (run_mode_reg[0] && run_mode_reg[1] && !wr_en && ev_pin[0]) [*3]
      |-> $stable(u_cnt[0]))
      else $error("event counter moved without an edge");

   a_edge_count: assert property (
      (run_mode_reg[0] && run_mode_reg[1] && ev_pin[0] && !wr_en)
      ##1 (!ev_pin[0] && !wr_en) ##1 !wr_en ##1 !wr_en
      |-> u_cnt[0] == $past(u_cnt[0], 2) + 16'h0001)
       else $error("falling edge not counted two cycles later");

   a_wrap_flag: assert property (
      u_wrap[0] |=> status_reg[0] && u_cnt[0] == 16'h0000)
      else $error("wrap did not clear count and set flag");

   a_irq_level: assert property (
      (|(status_reg & mask_reg)) [*2] |-> irq)
      else $error("unmasked flag without interrupt");

   a_t2_carry: assert property (
      (run_mode_reg[4] && !run_mode_reg[5] && !wr_en && !rld_mode
       && !updn_mode && u_cnt[2][7:0] == 8'hFF && u_cnt[2][15:8] != 8'hFF)
      |=> u_cnt[2][15:8] == $past(u_cnt[2][15:8]) + 8'h01)
      else $error("third unit did not carry into high byte");

   a_capture_copy: assert property (
      (cap_mode && trig_fall) |=> cap_reg == $past(u_cnt[2]) && status_reg[ST_TRIG_POS])
      else $error("capture missed count or flag");

   a_reload_up: assert property (
      (u_wrap[2] && rld_mode && !u_down[2]) |=> u_cnt[2] == rld_reg)
      else $error("auto-reload did not load reload value");

   a_down_dir: assert property (
      (run_mode_reg[4] && !run_mode_reg[5] && updn_mode && !trig_samp_reg
       && !wr_en && u_cnt[2] != rld_reg)
      |=> u_cnt[2] == $past(u_cnt[2]) - 16'h0001)
      else $error("trigger low did not count down");

   a_tout_toggle: assert property (
      (u2_ctrl_reg[U2_OUT_POS] && u_wrap[2]) |=> tmr_out != $past(tmr_out))
      else $error("timer output did not toggle on wrap");

endmodule

`default_nettype wire

// ---- tb/gptc_pins.sv ----
// Partner model: event sources and trigger pin in front of the timer/counter block
`timescale 1ns/1ns
`default_nettype none

module gptc_pins (
   // Clock
   input  wire logic mclk,
   // Pins toward the block
   output logic      ev0,
   output logic      ev1,
   output logic      ev2,
   output logic      trig
);
   // ************************************************************
   // Pin drivers
   // ************************************************************
   // Pins are plain driven levels, so idle event pins sit low and the trigger sits high
   initial begin
      ev0  = 1'b0;
      ev1  = 1'b0;
      ev2  = 1'b0;
      trig = 1'b1;
   end

   // Change one event pin just after an edge
   task automatic set_ev(input int u, input logic v);
      case (u)
         0: ev0 <= v;
         1: ev1 <= v;
         default: ev2 <= v;
      endcase
   endtask

   // One event; each level lasts whole cycles so the sampler cannot miss it
   task automatic pulse(input int u, input int hi, input int lo);
      set_ev(u, 1'b1);
      repeat ((hi < 1) ? 1 : hi) @(posedge mclk);
      set_ev(u, 1'b0);
      repeat ((lo < 1) ? 1 : lo) @(posedge mclk);
   endtask

   // Trigger level, held at least one cycle
   task automatic set_trig(input logic v);
      trig <= v;
      @(posedge mclk);
   endtask
endmodule

`default_nettype wire

// ---- tb/gptc_top_tb.sv ----
// Self-checking testbench of the three-unit timer/counter block
`timescale 1ns/1ns
`default_nettype none

module gptc_top_tb
   import gptc_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   logic        mclk = 1'b0;
   logic        rstn;
   logic [3:0]  addr;
   logic [7:0]  wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rd_data;
   wire logic   ev0;
   wire logic   ev1;
   wire logic   ev2;
   wire logic   trig;
   logic        tmr_out;
   logic        irq;
   logic        rd_pend = 1'b0;
   logic [7:0]  exp_q[$];
   logic [31:0] seed;
   logic [15:0] v;
   int          errors = 0;
   int          checked = 0;
   int          i;
   int          n;

   // Free-running machine clock
   always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

   gptc_pins pins (.mclk(mclk), .ev0(ev0), .ev1(ev1), .ev2(ev2), .trig(trig));

   gptc_top dut (
      .mclk(mclk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .event_input_zero(ev0), .event_input_one(ev1),
      .event_input_two(ev2), .capture_reload_trigger(trig), .tmr_out(tmr_out), .irq(irq)
   );

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One bus cycle; strobes stay up so back-to-back cycles need no gap
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      addr    <= a;
      wr_data <= w ? d : 8'h00;
      wr_en   <= w;
      rd_en   <= !w;
      if (!w)
         exp_q.push_back(d);
      @(posedge mclk);
   endtask

   task automatic idle();
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      idle();
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] d);
      // Spare cycle: a count moved by the last pin fall shows one cycle late
      idle();
      acc(1'b0, a, d);
      idle();
   endtask

   // Bounded wait for an interrupt level
   task automatic wait_irq(input logic lvl);
      for (n = 0; n < 64 && irq !== lvl; n++)
         @(posedge mclk);
      if (n == 64) begin
         errors++;
         report_and_stop();
      end
   endtask

   // ************************************************************
   // Result watcher
   // ************************************************************
   // Read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge mclk) begin
      if (rd_pend)
         chk_rd(rd_data, exp_q.pop_front());
      else if (rstn === 1'b1)
         chk_rd(rd_data, 8'h00);
      rd_pend <= rd_en;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      report_and_stop();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rstn    = 1'b0;
      addr    = 4'h0;
      wr_data = 8'h00;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      seed    = 32'haf8f;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      // Every place reads zero after reset, unmapped ones included
      for (i = 0; i < 16; i++)
         acc(1'b0, i[3:0], 8'h00);
      idle();
      chk_pin(irq, 1'b0);
      chk_pin(tmr_out, 1'b0);
      // Captured count is read-only; unmapped writes vanish
      wr(OFF_CAP_LO, 8'hA5);
      wr(4'hE, 8'h5A);
      rd(OFF_CAP_LO, 8'h00);
      rd(4'hE, 8'h00);
      // Timer counts every cycle, then wraps and interrupts
      wr(OFF_CNT_BASE, 8'hF0);
      wr(OFF_CNT_BASE + 4'h1, 8'hFF);
      wr(OFF_MASK, 8'h01);
      acc(1'b1, OFF_RUN_MODE, 8'h01);
      for (i = 0; i < 4; i++)
         acc(1'b0, OFF_CNT_BASE, 8'hF0 + i[7:0]);
      idle();
      wait_irq(1'b1);
      wr(OFF_RUN_MODE, 8'h00);
      rd(OFF_STATUS, 8'h01);
      wr(OFF_MASK, 8'h00);
      wait_irq(1'b0);
      wr(OFF_MASK, 8'h01);
      wait_irq(1'b1);
      wr(OFF_STATUS, 8'h01);
      wait_irq(1'b0);
      rd(OFF_STATUS, 8'h00);
      // A stopped unit ignores its pin
      wr(OFF_CNT_BASE, 8'h00);
      wr(OFF_CNT_BASE + 4'h1, 8'h00);
      pins.pulse(0, 1, 1);
      rd(OFF_CNT_BASE, 8'h00);
      // Exact moment a counted edge shows up
      wr(OFF_RUN_MODE, 8'h03);
      fork
         pins.pulse(0, 1, 3);
         begin
            repeat (2) @(posedge mclk);
            acc(1'b0, OFF_CNT_BASE, 8'h00);
            acc(1'b0, OFF_CNT_BASE, 8'h01);
            idle();
         end
      join
      // Random widths and start value on the second unit
      seed = lfsr(seed);
      v    = seed[15:0];
      wr(OFF_CNT_BASE + 4'h2, v[7:0]);
      wr(OFF_CNT_BASE + 4'h3, v[15:8]);
      wr(OFF_RUN_MODE, 8'h0C);
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         pins.pulse(1, 1 + int'(seed[1:0]), 1 + int'(seed[3:2]));
      end
      v = v + 16'h0008;
      rd(OFF_CNT_BASE + 4'h2, v[7:0]);
      rd(OFF_CNT_BASE + 4'h3, v[15:8]);
      // Capture on trigger fall while the third unit keeps counting
      wr(OFF_CNT_BASE + 4'h4, 8'h34);
      wr(OFF_CNT_BASE + 4'h5, 8'h12);
      wr(OFF_U2_CTRL, 8'h01);
      wr(OFF_RUN_MODE, 8'h30);
      wr(OFF_STATUS, 8'h0F);
      pins.set_trig(1'b0);
      repeat (4) @(posedge mclk);
      rd(OFF_CAP_LO, 8'h34);
      rd(OFF_CAP_HI, 8'h12);
      rd(OFF_STATUS, 8'h08);
      pins.set_trig(1'b1);
      pins.pulse(2, 1, 2);
      rd(OFF_CNT_BASE + 4'h4, 8'h35);
      rd(OFF_CAP_LO, 8'h34);
      // Trigger fall forces a reload
      wr(OFF_RLD_LO, 8'hF0);
      wr(OFF_RLD_HI, 8'hFF);
      wr(OFF_U2_CTRL, 8'h0A);
      wr(OFF_STATUS, 8'h0F);
      pins.set_trig(1'b0);
      repeat (4) @(posedge mclk);
      rd(OFF_CNT_BASE + 4'h4, 8'hF0);
      rd(OFF_CNT_BASE + 4'h5, 8'hFF);
      rd(OFF_STATUS, 8'h08);
      pins.set_trig(1'b1);
      // Up auto-reload on wrap, timer output toggles
      wr(OFF_CNT_BASE + 4'h4, 8'hFE);
      wr(OFF_U2_CTRL, 8'h12);
      wr(OFF_STATUS, 8'h0F);
      for (i = 0; i < 3; i++)
         pins.pulse(2, 1, 1);
      rd(OFF_CNT_BASE + 4'h4, 8'hF1);
      rd(OFF_STATUS, 8'h04);
      chk_pin(tmr_out, 1'b1);
      // Direction picked by trigger level: low counts down to the reload value
      wr(OFF_U2_CTRL, 8'h06);
      pins.set_trig(1'b0);
      wr(OFF_CNT_BASE + 4'h4, 8'hF2);
      wr(OFF_STATUS, 8'h0F);
      for (i = 0; i < 3; i++)
         pins.pulse(2, 2, 1);
      rd(OFF_CNT_BASE + 4'h4, 8'hFF);
      rd(OFF_STATUS, 8'h04);
      // High trigger counts up again and wraps into the reload value
      pins.set_trig(1'b1);
      wr(OFF_STATUS, 8'h0F);
      pins.pulse(2, 1, 1);
      rd(OFF_CNT_BASE + 4'h4, 8'hF0);
      rd(OFF_STATUS, 8'h04);
      // Third unit as a plain timer carries into its high byte
      wr(OFF_U2_CTRL, 8'h00);
      wr(OFF_CNT_BASE + 4'h4, 8'hFD);
      wr(OFF_CNT_BASE + 4'h5, 8'h00);
      acc(1'b1, OFF_RUN_MODE, 8'h10);
      acc(1'b0, OFF_CNT_BASE + 4'h4, 8'hFD);
      acc(1'b0, OFF_CNT_BASE + 4'h4, 8'hFE);
      acc(1'b0, OFF_CNT_BASE + 4'h5, 8'h00);
      acc(1'b0, OFF_CNT_BASE + 4'h5, 8'h01);
      idle();
      repeat (3) @(posedge mclk);
      report_and_stop();
   end
endmodule

`default_nettype wire
